// ===== rtl/dual_register_file.sv
// Purpose: integer and float register files with operand, branch,
//          move and load/store formatting around them
// Assumes: outer decoder supplies op class and format per instruction
// Notes:   one instruction accepted per cycle, answers one cycle later
//
// Notes on behaviour
// - integer file has 32 entries of 64 bits
// - integer register 31 reads zero, writes to it are dropped
// - separate float file has 32 entries of 64 bits
// - float register 31 reads zero, writes to it are dropped
// - 32-bit integer written to a register carries 33 copies of its sign
// - 32-bit float widens exponent by three bits, adds 29 low zeros
// - 32-bit arithmetic results use the same canonical forms as loads
// - 32-bit add, sub, mul differ from 64-bit only in overflow and form
// - integer op reads two sources, second may be 8-bit literal, one dest
// - integer overflow trap enable comes only from the function field
// - float trap enables and rounding come only from the function field
// - branches test sign and zero; integer branches also test low bit
// - unconditional branch may write return address to an integer reg
// - computed jump goes to the full 64-bit register value
// - moves between files copy bits unchanged, no memory access
// - aligned 8, 16, 32, 64-bit transfers at flat 64-bit addresses
// - legacy float loads and stores swap 16-bit words
// - no condition flags; branches decide from register values
// - no global width mode; width chosen per instruction
// - every instruction word is 32 bits with a regular layout
// - unspecified results never expose other state
// - undefined operations never hang the block
`include "dual_register_file_consts.svh"
`default_nettype none
module dual_register_file (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              op_valid,
  input  wire dual_register_file_pkg::op_class_t op_class,
  input  wire dual_register_file_pkg::fmt_t      op_fmt,
  input  wire logic [31:0]                       op_inst,
  input  wire dual_register_file_pkg::word_t     op_pc,
  input  wire logic                              wb_valid,
  input  wire logic                              wb_fp,
  input  wire dual_register_file_pkg::ridx_t     wb_idx,
  input  wire dual_register_file_pkg::fmt_t      wb_fmt,
  input  wire dual_register_file_pkg::word_t     wb_data,
  output logic                                   wb_busy,
  output logic                                   issue_q,
  output logic [63:0]                            src_a_q,
  output logic [63:0]                            src_b_q,
  output logic [4:0]                             dest_idx_q,
  output logic                                   dest_fp_q,
  output logic                                   long_op_q,
  output logic                                   int_trap_en_q,
  output logic [2:0]                             fp_trap_en_q,
  output logic [1:0]                             fp_round_q,
  output logic                                   redirect_q,
  output logic [63:0]                            target_q,
  output logic                                   mem_req_q,
  output logic                                   mem_store_q,
  output logic [1:0]                             mem_size_q,
  output logic [63:0]                            mem_addr_q,
  output logic [63:0]                            mem_wdata_q,
  output logic                                   mem_misalign_q,
  output logic                                   illegal_q
);
  import dual_register_file_pkg::*;

  // ----------------------------------------
  // register files
  // ----------------------------------------
  ridx_t f_ra, f_rb, f_rc;
  word_t ia_data, ib_data, fa_data, fb_data;
  logic  iw_valid_q, iw_valid_d, iw_fp_q, iw_fp_d;
  ridx_t iw_idx_q, iw_idx_d;
  word_t iw_data_q, iw_data_d;
  logic  wb_take, int_we, fp_we;
  ridx_t w_idx;
  word_t w_data, ld_canon, st_img;
  fmt_t  st_fmt;

  assign f_ra = op_inst[`F_RA];
  assign f_rb = op_inst[`F_RB];
  assign f_rc = op_inst[`F_RC];

  // internal writes own the ports; outside write-back waits while one is pending
  assign wb_take = wb_valid && !iw_valid_q;
  assign int_we  = iw_valid_q ? !iw_fp_q : (wb_take && !wb_fp);
  assign fp_we   = iw_valid_q ? iw_fp_q : (wb_take && wb_fp);
  assign w_idx   = iw_valid_q ? iw_idx_q : wb_idx;
  assign w_data  = iw_valid_q ? iw_data_q : ld_canon;
  assign wb_busy = iw_valid_q;

  rf_bank u_int_bank (
    .clk       (clk),
    .arst_n    (arst_n),
    .rd_a_idx  (f_ra),
    .rd_b_idx  (f_rb),
    .wr_en     (int_we),
    .wr_idx    (w_idx),
    .wr_data   (w_data),
    .rd_a_data (ia_data),
    .rd_b_data (ib_data)
  );

  rf_bank u_fp_bank (
    .clk       (clk),
    .arst_n    (arst_n),
    .rd_a_idx  (f_ra),
    .rd_b_idx  (f_rb),
    .wr_en     (fp_we),
    .wr_idx    (w_idx),
    .wr_data   (w_data),
    .rd_a_data (fa_data),
    .rd_b_data (fb_data)
  );

  canon_fmt u_canon (
    .ld_fmt   (wb_fmt),
    .ld_data  (wb_data),
    .st_fmt   (st_fmt),
    .st_reg   (st_fmt inside {FMT_S, FMT_T, FMT_F, FMT_G} ? fa_data : ia_data),
    .ld_canon (ld_canon),
    .st_img   (st_img)
  );
  assign st_fmt = op_fmt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic cond_met(input cond_t c, input word_t v, input logic fp);
    logic zero;
    logic neg;
    zero = fp ? (v[62:0] == 63'h0) : (v == 64'h0);
    neg  = v[63] && !zero;
    case (c)
      C_EQ:    cond_met = zero;
      C_NE:    cond_met = !zero;
      C_LT:    cond_met = neg;
      C_LE:    cond_met = neg || zero;
      C_GT:    cond_met = !neg && !zero;
      C_GE:    cond_met = !neg;
      C_LBC:   cond_met = !v[0];
      C_LBS:   cond_met = v[0];
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

  function automatic logic [2:0] align_mask(input fmt_t f);
    case (f)
      FMT_B:               align_mask = 3'h0;
      FMT_W:               align_mask = 3'h1;
      FMT_L, FMT_S, FMT_F: align_mask = 3'h3;
      default:             align_mask = 3'h7;
    endcase
  endfunction : align_mask

  // ----------------------------------------
  // decode and operand stage
  // ----------------------------------------
  logic        issue_d, dest_fp_d, long_d, itrap_d, redir_d, mreq_d, mst_d, misal_d;
  logic        ill_d;
  logic [2:0]  ftrap_d;
  logic [1:0]  frnd_d, msize_d;
  logic [4:0]  dest_d;
  word_t       src_a_d, src_b_d, target_d, maddr_d, mwdata_d, br_target, link;
  logic [10:0] ffunc;
  logic [6:0]  ifunc;
  logic        is_float_fmt;

  assign ifunc     = op_inst[`F_IFUNC];
  assign ffunc     = op_inst[`F_FFUNC];
  assign link      = op_pc + `PC_STEP;
  assign br_target = link + {{41{op_inst[20]}}, op_inst[`F_DISP21], 2'b00};
  assign is_float_fmt = op_fmt inside {FMT_S, FMT_T, FMT_F, FMT_G};

  always_comb begin
    // everything not driven by the op stays zero: nothing stale leaks out
    issue_d = 1'b0; src_a_d = '0; src_b_d = '0; dest_d = '0;
    dest_fp_d = 1'b0; long_d = 1'b0; itrap_d = 1'b0; ftrap_d = '0;
    frnd_d = '0; redir_d = 1'b0; target_d = '0; mreq_d = 1'b0;
    mst_d = 1'b0; msize_d = '0; maddr_d = '0; mwdata_d = '0;
    misal_d = 1'b0; ill_d = 1'b0;
    iw_valid_d = 1'b0; iw_fp_d = 1'b0; iw_idx_d = '0; iw_data_d = '0;
    if (op_valid) begin
      case (op_class)
        OP_INT: begin
          issue_d = 1'b1;
          src_a_d = ia_data;
          src_b_d = op_inst[`F_LITSEL] ? {56'h0, op_inst[`F_LIT]} : ib_data;
          dest_d  = f_rc;
          long_d  = !ifunc[`IFN_QUAD];
          itrap_d = ifunc[`IFN_TRAP];
        end
        OP_FLT: begin
          issue_d   = 1'b1;
          src_a_d   = fa_data;
          src_b_d   = fb_data;
          dest_d    = f_rc;
          dest_fp_d = 1'b1;
          ftrap_d   = ffunc[`FFN_TRAP];
          frnd_d    = ffunc[`FFN_RND];
        end
        OP_LOAD, OP_STORE: begin
          mreq_d    = 1'b1;
          mst_d     = (op_class == OP_STORE);
          maddr_d   = ib_data + {{48{op_inst[15]}}, op_inst[`F_DISP16]};
          misal_d   = |(maddr_d[2:0] & align_mask(op_fmt));
          msize_d   = (align_mask(op_fmt) == 3'h0) ? 2'h0 :
                      (align_mask(op_fmt) == 3'h1) ? 2'h1 :
                      (align_mask(op_fmt) == 3'h3) ? 2'h2 : 2'h3;
          mwdata_d  = (op_class == OP_STORE) ? st_img : '0;
          dest_d    = (op_class == OP_LOAD) ? f_ra : '0;
          dest_fp_d = (op_class == OP_LOAD) && is_float_fmt;
        end
        OP_BCOND: begin
          redir_d  = cond_met(cond_t'(op_inst[`F_COND]), ia_data, 1'b0);
          target_d = redir_d ? br_target : '0;
        end
        OP_FBCOND: begin
          // low-bit tests have no meaning on the float side: flagged, not taken
          if (op_inst[`F_COND] inside {C_LBC, C_LBS}) begin
            ill_d = 1'b1;
          end else begin
            redir_d  = cond_met(cond_t'(op_inst[`F_COND]), fa_data, 1'b1);
            target_d = redir_d ? br_target : '0;
          end
        end
        OP_BR: begin
          redir_d    = 1'b1;
          target_d   = br_target;
          iw_valid_d = (f_ra != `RF_ZERO_IDX);
          iw_idx_d   = f_ra;
          iw_data_d  = link;
        end
        OP_JMP: begin
          redir_d    = 1'b1;
          target_d   = ib_data;
          iw_valid_d = (f_ra != `RF_ZERO_IDX);
          iw_idx_d   = f_ra;
          iw_data_d  = link;
        end
        OP_ITOF: begin
          iw_valid_d = 1'b1;
          iw_fp_d    = 1'b1;
          iw_idx_d   = f_rc;
          iw_data_d  = ia_data;
        end
        OP_FTOI: begin
          iw_valid_d = 1'b1;
          iw_idx_d   = f_rc;
          iw_data_d  = fa_data;
        end
        default: begin
          ill_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      issue_q <= 1'b0; src_a_q <= '0; src_b_q <= '0; dest_idx_q <= '0;
      dest_fp_q <= 1'b0; long_op_q <= 1'b0; int_trap_en_q <= 1'b0;
      fp_trap_en_q <= '0; fp_round_q <= '0; redirect_q <= 1'b0;
      target_q <= '0; mem_req_q <= 1'b0; mem_store_q <= 1'b0;
      mem_size_q <= '0; mem_addr_q <= '0; mem_wdata_q <= '0;
      mem_misalign_q <= 1'b0; illegal_q <= 1'b0;
      iw_valid_q <= 1'b0; iw_fp_q <= 1'b0; iw_idx_q <= '0; iw_data_q <= '0;
    end else begin
      issue_q <= issue_d; src_a_q <= src_a_d; src_b_q <= src_b_d;
      dest_idx_q <= dest_d; dest_fp_q <= dest_fp_d; long_op_q <= long_d;
      int_trap_en_q <= itrap_d; fp_trap_en_q <= ftrap_d; fp_round_q <= frnd_d;
      redirect_q <= redir_d; target_q <= target_d; mem_req_q <= mreq_d;
      mem_store_q <= mst_d; mem_size_q <= msize_d; mem_addr_q <= maddr_d;
      mem_wdata_q <= mwdata_d; mem_misalign_q <= misal_d; illegal_q <= ill_d;
      iw_valid_q <= iw_valid_d; iw_fp_q <= iw_fp_d;
      iw_idx_q <= iw_idx_d; iw_data_q <= iw_data_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_jump;
    op_valid && op_class == OP_JMP;
  endsequence
  sequence s_link;
    op_valid && (op_class == OP_BR) && (f_ra != `RF_ZERO_IDX);
  endsequence

  AST_LONG_CANON: assert property (@(posedge clk) disable iff (!arst_n)
    (wb_fmt == FMT_L) |-> ld_canon[63:31] == {33{wb_data[31]}})
    else $error("long result not sign-filled");
  AST_SINGLE_CANON: assert property (@(posedge clk) disable iff (!arst_n)
    (wb_fmt inside {FMT_S, FMT_F}) |-> ld_canon[28:0] == '0 && ld_canon[63] == (
      wb_fmt == FMT_S ? wb_data[31] : wb_data[15]))
    else $error("single float not canonical");
  AST_LINK_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    s_link |=> iw_valid_q && !iw_fp_q && iw_data_q == $past(op_pc) + `PC_STEP
      ##1 (!iw_valid_q || $past(op_valid) && $past(op_class) inside {OP_BR, OP_JMP,
      OP_ITOF, OP_FTOI}))
    else $error("return address not written");
  AST_JUMP_TARGET: assert property (@(posedge clk) disable iff (!arst_n)
    s_jump |=> redirect_q && target_q == $past(ib_data))
    else $error("jump target wrong");
  AST_MOVE_RAW: assert property (@(posedge clk) disable iff (!arst_n)
    (op_valid && op_class == OP_ITOF) |=> iw_fp_q && iw_data_q == $past(ia_data)
      && !mem_req_q)
    else $error("int to float move altered");
  AST_LITERAL: assert property (@(posedge clk) disable iff (!arst_n)
    (op_valid && op_class == OP_INT && op_inst[`F_LITSEL])
      |=> src_b_q == {56'h0, $past(op_inst[20:13])})
    else $error("literal operand wrong");
  AST_TRAP_FIELD: assert property (@(posedge clk) disable iff (!arst_n)
    (op_valid && op_class == OP_INT) |=> issue_q && int_trap_en_q == $past(ifunc[6]))
    else $error("trap enable not from function field");
  AST_NO_HANG: assert property (@(posedge clk) disable iff (!arst_n)
    illegal_q |-> !redirect_q && !iw_valid_q && !mem_req_q ##1 (!illegal_q || $past(op_valid)))
    else $error("undefined op left side effects");
  AST_ALIGN: assert property (@(posedge clk) disable iff (!arst_n)
    (mem_req_q && mem_size_q == 2'h3) |-> mem_misalign_q == (mem_addr_q[2:0] != 3'h0))
    else $error("quad alignment check wrong");
endmodule : dual_register_file
`default_nettype wire

// ===== rtl/dual_register_file_consts.svh
// Purpose: shared constants of the dual register file
// Assumes: included by bare name
// Notes:   field macros expand to part-selects of the instruction word
`ifndef DUAL_REGISTER_FILE_CONSTS_SVH
`define DUAL_REGISTER_FILE_CONSTS_SVH

`define RF_DEPTH     32
`define RF_ZERO_IDX  5'h1f
`define F_RA         25:21
`define F_RB         20:16
`define F_RC         4:0
`define F_LIT        20:13
`define F_LITSEL     12
`define F_IFUNC      11:5
`define F_FFUNC      15:5
`define F_DISP16     15:0
`define F_DISP21     20:0
`define F_COND       28:26
`define IFN_TRAP     6
`define IFN_QUAD     5
`define FFN_TRAP     10:8
`define FFN_RND      7:6
`define PC_STEP      64'h0000_0000_0000_0004
`define EXP_HI_PAD   3'h0
`define EXP_LO_PAD   3'h7
`define FRAC_PAD     29'h0000_0000

`endif

// ===== rtl/dual_register_file_pkg.sv
// Purpose: types shared by the dual register file and its users
// Assumes: nothing
// Notes:   op class comes from the outer decoder
`default_nettype none
package dual_register_file_pkg;
  typedef logic [63:0] word_t;
  typedef logic [4:0]  ridx_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_INT = 4'h1, OP_FLT = 4'h2, OP_LOAD = 4'h3,
    OP_STORE = 4'h4, OP_BCOND = 4'h5, OP_FBCOND = 4'h6, OP_BR = 4'h7,
    OP_JMP = 4'h8, OP_ITOF = 4'h9, OP_FTOI = 4'ha
  } op_class_t;
  // memory/result formats: B W L Q ints, S T ieee, F G legacy float
  typedef enum logic [2:0] {
    FMT_B = 3'h0, FMT_W = 3'h1, FMT_L = 3'h2, FMT_Q = 3'h3,
    FMT_S = 3'h4, FMT_T = 3'h5, FMT_F = 3'h6, FMT_G = 3'h7
  } fmt_t;
  typedef enum logic [2:0] {
    C_EQ = 3'h0, C_NE = 3'h1, C_LT = 3'h2, C_LE = 3'h3,
    C_GT = 3'h4, C_GE = 3'h5, C_LBC = 3'h6, C_LBS = 3'h7
  } cond_t;
endpackage : dual_register_file_pkg
`default_nettype wire

// ===== rtl/rf_bank.sv
// Purpose: 32 x 64 register bank, two reads, one write, entry 31 zero
// Assumes: single clock
// Notes:   reads bypass the write of the same cycle
`include "dual_register_file_consts.svh"
`default_nettype none
module rf_bank (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire dual_register_file_pkg::ridx_t rd_a_idx,
  input  wire dual_register_file_pkg::ridx_t rd_b_idx,
  input  wire logic                          wr_en,
  input  wire dual_register_file_pkg::ridx_t wr_idx,
  input  wire dual_register_file_pkg::word_t wr_data,
  output logic [63:0]                        rd_a_data,
  output logic [63:0]                        rd_b_data
);
  import dual_register_file_pkg::*;

  word_t mem_q [`RF_DEPTH];
  word_t mem_d [`RF_DEPTH];

  always_comb begin
    mem_d = mem_q;
    if (wr_en && wr_idx != `RF_ZERO_IDX) begin
      mem_d[wr_idx] = wr_data;
    end
  end

  // cleared at reset so no earlier context leaks out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `RF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rd_a_data = (rd_a_idx == `RF_ZERO_IDX) ? '0 :
                     (wr_en && wr_idx == rd_a_idx) ? wr_data : mem_q[rd_a_idx];
  assign rd_b_data = (rd_b_idx == `RF_ZERO_IDX) ? '0 :
                     (wr_en && wr_idx == rd_b_idx) ? wr_data : mem_q[rd_b_idx];

  AST_ZERO_AFTER_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_en && wr_idx == `RF_ZERO_IDX) ##1 (rd_a_idx == `RF_ZERO_IDX) |-> rd_a_data == '0)
    else $error("zero register read back nonzero");
  AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_en && wr_idx != `RF_ZERO_IDX) |=> mem_q[$past(wr_idx)] == $past(wr_data))
    else $error("register write lost");
endmodule : rf_bank
`default_nettype wire

// ===== rtl/canon_fmt.sv
// Purpose: canonical register image of loaded data, memory image of stores
// Assumes: memory data is low-justified
// Notes:   purely combinational
`include "dual_register_file_consts.svh"
`default_nettype none
module canon_fmt (
  input  wire dual_register_file_pkg::fmt_t  ld_fmt,
  input  wire dual_register_file_pkg::word_t ld_data,
  input  wire dual_register_file_pkg::fmt_t  st_fmt,
  input  wire dual_register_file_pkg::word_t st_reg,
  output logic [63:0]                        ld_canon,
  output logic [63:0]                        st_img
);
  import dual_register_file_pkg::*;

  function automatic logic [10:0] s_exp(input logic [7:0] e);
    if (e == 8'hff) begin
      s_exp = 11'h7ff;
    end else if (e == 8'h00) begin
      s_exp = 11'h000;
    end else begin
      s_exp = {e[7], e[7] ? `EXP_HI_PAD : `EXP_LO_PAD, e[6:0]};
    end
  endfunction : s_exp

  function automatic logic [10:0] f_exp(input logic [7:0] e);
    if (!e[7] && e[6:0] == 7'h00) begin
      f_exp = 11'h000;
    end else begin
      f_exp = {e[7], e[7] ? `EXP_HI_PAD : `EXP_LO_PAD, e[6:0]};
    end
  endfunction : f_exp

  always_comb begin
    case (ld_fmt)
      FMT_B:   ld_canon = {56'h0, ld_data[7:0]};
      FMT_W:   ld_canon = {48'h0, ld_data[15:0]};
      FMT_L:   ld_canon = {{32{ld_data[31]}}, ld_data[31:0]};
      FMT_S:   ld_canon = {ld_data[31], s_exp(ld_data[30:23]), ld_data[22:0],
                           `FRAC_PAD};
      FMT_F:   ld_canon = {ld_data[15], f_exp(ld_data[14:7]), ld_data[6:0],
                           ld_data[31:16], `FRAC_PAD};
      FMT_G:   ld_canon = {ld_data[15:0], ld_data[31:16], ld_data[47:32],
                           ld_data[63:48]};
      default: ld_canon = ld_data;
    endcase
  end

  always_comb begin
    case (st_fmt)
      FMT_B:   st_img = {56'h0, st_reg[7:0]};
      FMT_W:   st_img = {48'h0, st_reg[15:0]};
      FMT_L:   st_img = {32'h0, st_reg[31:0]};
      FMT_S:   st_img = {32'h0, st_reg[63:62], st_reg[58:29]};
      FMT_F:   st_img = {32'h0, st_reg[44:29], st_reg[63:62], st_reg[58:45]};
      FMT_G:   st_img = {st_reg[15:0], st_reg[31:16], st_reg[47:32],
                         st_reg[63:48]};
      default: st_img = st_reg;
    endcase
  end
endmodule : canon_fmt
`default_nettype wire

// ===== dv/wb_source.sv
// Purpose: write-back source standing in for the execute and load paths
// Assumes: requests launched and released on the falling edge
// Notes:   a refused request is held unchanged until it is taken
`default_nettype none
module wb_source (
  input  wire logic                          clk,
  input  wire logic                          go,
  input  wire logic                          req_fp,
  input  wire dual_register_file_pkg::ridx_t req_idx,
  input  wire dual_register_file_pkg::fmt_t  req_fmt,
  input  wire dual_register_file_pkg::word_t req_data,
  input  wire logic                          wb_busy,
  output logic                               wb_valid,
  output logic                               wb_fp,
  output dual_register_file_pkg::ridx_t      wb_idx,
  output dual_register_file_pkg::fmt_t       wb_fmt,
  output dual_register_file_pkg::word_t      wb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import dual_register_file_pkg::*;
  logic took = 1'b0;
  // ---------------------------------
  // launch, hold while busy, release
  // ---------------------------------
  initial begin
    {wb_valid, wb_fp, wb_idx, wb_data} = 71'h0;
    wb_fmt = FMT_Q;
  end
  always @(posedge clk) took <= wb_valid && !wb_busy;
  // released data turns over so a stale word never passes for a fresh one
  always @(negedge clk) begin
    if (wb_valid && took) begin
      wb_valid <= 1'b0;
      wb_data  <= ~wb_data;
    end else if (go && !wb_valid) begin
      {wb_valid, wb_fp, wb_idx, wb_data} <= {1'b1, req_fp, req_idx, req_data};
      wb_fmt <= req_fmt;
    end
  end
endmodule : wb_source
`default_nettype wire

// ===== dv/dual_register_file_tb.sv
// Purpose: self-checking bench of the dual register file
// Assumes: inputs move on the falling edge
// Notes:   moves take ra as source and rc as destination
`default_nettype none
module dual_register_file_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dual_register_file_pkg::*;
  // ----------------
  // signals and dut
  // ----------------
  logic        clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, go = 1'b0, g_fp = 1'b0;
  op_class_t   op_class = OP_NONE;
  fmt_t        op_fmt = FMT_Q, g_fmt = FMT_Q, wb_fmt;
  logic [31:0] op_inst = 32'h0;
  word_t       op_pc = 64'h0, g_data = 64'h0, wb_data;
  ridx_t       g_idx = 5'h0, wb_idx;
  logic        wb_valid, wb_fp, wb_busy, issue_q, dest_fp_q, long_op_q, int_trap_en_q;
  logic        redirect_q, mem_req_q, mem_store_q, mem_misalign_q, illegal_q;
  logic [63:0] src_a_q, src_b_q, target_q, mem_addr_q, mem_wdata_q;
  logic [4:0]  dest_idx_q;
  logic [2:0]  fp_trap_en_q;
  logic [1:0]  fp_round_q, mem_size_q;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  initial forever #2 clk = ~clk;
  dual_register_file dut_u (.clk, .arst_n, .op_valid, .op_class, .op_fmt, .op_inst,
    .op_pc, .wb_valid, .wb_fp, .wb_idx, .wb_fmt, .wb_data, .wb_busy, .issue_q, .src_a_q,
    .src_b_q, .dest_idx_q, .dest_fp_q, .long_op_q, .int_trap_en_q, .fp_trap_en_q,
    .fp_round_q, .redirect_q, .target_q, .mem_req_q, .mem_store_q, .mem_size_q,
    .mem_addr_q, .mem_wdata_q, .mem_misalign_q, .illegal_q);
  wb_source src_u (.clk, .go, .req_fp(g_fp), .req_idx(g_idx), .req_fmt(g_fmt),
    .req_data(g_data), .wb_busy, .wb_valid, .wb_fp, .wb_idx, .wb_fmt, .wb_data);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [63:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] rr(input ridx_t a, b, c);
    return {6'h0, a, b, 11'h0, c};
  endfunction : rr
  // answer of the op stands at the falling edge where this returns
  task automatic op(input op_class_t c, input fmt_t f, input logic [31:0] i, input word_t pc);
    {op_valid, op_class, op_fmt, op_inst, op_pc} <= {1'b1, c, f, i, pc};
    @(negedge clk);
  endtask : op
  task automatic wr(input logic fp, input ridx_t idx, input fmt_t f, input word_t d);
    op_valid <= 1'b0;
    for (int k = 0; k < 8 && wb_valid !== 1'b0; k++) @(negedge clk);
    {g_fp, g_idx, g_fmt, g_data, go} <= {fp, idx, f, d, 1'b1};
    @(negedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (int k = 0; k < 8 && wb_valid !== 1'b0; k++) @(negedge clk);
  endtask : wr
  task automatic t_int();
    wr(1'b0, 5'd5, FMT_Q, 64'h0123_4567_89ab_cdef);
    wr(1'b0, 5'd31, FMT_Q, 64'hffff_ffff_ffff_ffff);
    wr(1'b0, 5'd6, FMT_L, 64'h8000_0001);
    op(OP_INT, FMT_Q, rr(5'd5, 5'd31, 5'd6), 64'h0);
    chk("src_a", 64'h0123_4567_89ab_cdef, src_a_q);
    chk("r31", 64'h0, src_b_q);
    chk("dest", 64'h6, 64'(dest_idx_q));
    chk("issue", 64'h1, 64'(issue_q));
    op(OP_INT, FMT_Q, {6'h0, 5'd6, 8'hab, 1'b1, 7'h40, 5'd3}, 64'h0);
    chk("long_in", 64'hffff_ffff_8000_0001, src_a_q);
    chk("lit", 64'hab, src_b_q);
    chk("trap", 64'h1, 64'(int_trap_en_q));
    chk("long", 64'h1, 64'(long_op_q));
    op(OP_INT, FMT_Q, {6'h0, 5'd6, 5'd5, 11'h020, 5'd3}, 64'h0);
    chk("trap", 64'h0, 64'(int_trap_en_q));
    chk("long", 64'h0, 64'(long_op_q));
    chk("src_b", 64'h0123_4567_89ab_cdef, src_b_q);
  endtask : t_int
  task automatic t_fp();
    wr(1'b1, 5'd2, FMT_S, 64'h3f80_0000);
    wr(1'b1, 5'd7, FMT_F, 64'h0000_3f80);
    wr(1'b1, 5'd31, FMT_Q, 64'h1);
    wr(1'b0, 5'd2, FMT_Q, 64'h5);
    wr(1'b1, 5'd8, FMT_G, 64'h0011_2233_4455_6677);
    op(OP_FLT, FMT_T, {6'h0, 5'd2, 5'd7, 3'h5, 2'h2, 6'h0, 5'd1}, 64'h0);
    chk("f_single", 64'h3ff0_0000_0000_0000, src_a_q);
    chk("f_legacy", 64'h3ff0_0000_0000_0000, src_b_q);
    chk("dest_fp", 64'h1, 64'(dest_fp_q));
    chk("fp_trap", 64'h5, 64'(fp_trap_en_q));
    chk("round", 64'h2, 64'(fp_round_q));
    op(OP_FLT, FMT_T, {6'h0, 5'd31, 5'd2, 3'h2, 2'h1, 6'h0, 5'd1}, 64'h0);
    chk("f31", 64'h0, src_a_q);
    chk("fp_trap", 64'h2, 64'(fp_trap_en_q));
    chk("round", 64'h1, 64'(fp_round_q));
    op(OP_FLT, FMT_T, rr(5'd8, 5'd31, 5'd1), 64'h0);
    chk("g_swap", 64'h6677_4455_2233_0011, src_a_q);
  endtask : t_fp
  task automatic t_br();
    wr(1'b0, 5'd9, FMT_Q, 64'hffff_ffff_ffff_fffd);
    // minus three: ne lt le and low bit set are taken
    for (int c = 0; c < 8; c++) begin
      op(OP_BCOND, FMT_Q, {3'h0, 3'(c), 5'd9, 21'h10}, 64'h1000);
      chk("taken", 64'(c == 1 || c == 2 || c == 3 || c == 7), 64'(redirect_q));
    end
    chk("target", 64'h1044, target_q);
    op(OP_FBCOND, FMT_Q, {3'h0, 3'h6, 5'd2, 21'h10}, 64'h1000);
    chk("illegal", 64'h1, 64'(illegal_q));
    // write-back launched against the link write, so it is refused once
    {g_fp, g_idx, g_fmt, g_data, go} <= {1'b0, 5'd14, FMT_Q, 64'h77, 1'b1};
    op(OP_BR, FMT_Q, {3'h0, 3'h0, 5'd3, 21'h1f_fffe}, 64'h2000);
    go <= 1'b0;
    chk("br_target", 64'h1ffc, target_q);
    chk("busy", 64'h1, 64'(wb_busy));
    op(OP_INT, FMT_Q, rr(5'd3, 5'd31, 5'd1), 64'h0);
    chk("link", 64'h2004, src_a_q);
    wr(1'b0, 5'd4, FMT_Q, 64'h8765_4321_0000_0003);
    op(OP_JMP, FMT_Q, rr(5'd31, 5'd4, 5'd31), 64'h3000);
    chk("jump", 64'h8765_4321_0000_0003, target_q);
    op(OP_ITOF, FMT_Q, rr(5'd9, 5'd31, 5'd12), 64'h0);
    chk("no_mem", 64'h0, 64'(mem_req_q));
    op(OP_FTOI, FMT_Q, rr(5'd7, 5'd31, 5'd13), 64'h0);
    op(OP_FLT, FMT_T, rr(5'd12, 5'd31, 5'd1), 64'h0);
    chk("itof", 64'hffff_ffff_ffff_fffd, src_a_q);
    op(OP_INT, FMT_Q, rr(5'd13, 5'd14, 5'd1), 64'h0);
    chk("ftoi", 64'h3ff0_0000_0000_0000, src_a_q);
    chk("held_wb", 64'h77, src_b_q);
  endtask : t_br
  task automatic t_mem();
    wr(1'b0, 5'd10, FMT_Q, 64'h1000);
    for (int f = 0; f < 4; f++) begin
      op(OP_LOAD, fmt_t'(f), {6'h0, 5'd1, 5'd10, 16'h0008}, 64'h0);
      chk("size", 64'(f), 64'(mem_size_q));
      chk("addr", 64'h1008, mem_addr_q);
      chk("align", 64'h0, 64'(mem_misalign_q));
    end
    op(OP_LOAD, FMT_L, {6'h0, 5'd1, 5'd10, 16'hfffe}, 64'h0);
    chk("addr", 64'h0ffe, mem_addr_q);
    chk("align", 64'h1, 64'(mem_misalign_q));
    op(OP_STORE, FMT_F, {6'h0, 5'd7, 5'd10, 16'h0}, 64'h0);
    chk("store", 64'h1, 64'(mem_store_q));
    chk("f_image", 64'h0000_3f80, mem_wdata_q);
    op(op_class_t'(4'hf), FMT_Q, 32'h0, 64'h0);
    chk("undef", 64'h1, 64'(illegal_q));
    op(OP_INT, FMT_Q, rr(5'd10, 5'd31, 5'd1), 64'h0);
    chk("recover", 64'h1000, src_a_q);
    arst_n <= 1'b0;
    @(negedge clk);
    chk("rst_out", 64'h0, src_a_q);
    arst_n <= 1'b1;
    op(OP_INT, FMT_Q, rr(5'd10, 5'd31, 5'd1), 64'h0);
    chk("rst_reg", 64'h0, src_a_q);
  endtask : t_mem
  initial begin
    repeat (12) @(negedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    t_int();
    t_fp();
    t_br();
    t_mem();
    conclude();
  end
endmodule : dual_register_file_tb
`default_nettype wire
